/* File: spi_cmd_pkg.sv */
// Package with opcodes, table layout, timing constants and carrier types for the command block.
package spi_cmd_pkg;
   localparam logic [7:0]  OP_PROG_SEC   = 8'h42;
   localparam logic [7:0]  OP_READ_SEC   = 8'h48;
   localparam logic [7:0]  OP_RST_EN     = 8'h66;
   localparam logic [7:0]  OP_RST        = 8'h99;
   localparam logic [7:0]  OP_DISC       = 8'h5a;
   localparam logic [7:0]  OP_WRITE_ENABLE_COMMAND       = 8'h06;
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          T_PROG_US     = 3000;
   localparam int          T_RST_US      = 30;
   localparam int          PROG_CYCLES   = T_PROG_US * 1000 / CLK_PERIOD_NS;
   localparam int          RST_CYCLES    = T_RST_US * 1000 / CLK_PERIOD_NS;
   localparam int          PAGE_COUNT    = 4;
   localparam int          PAGE_BYTES    = 256;
   localparam int          DISC_BYTES    = 24;
   localparam logic [7:0]  BLANK_BYTE    = 8'hff;
   localparam logic [23:0] ADDR_RESET    = 24'h000000;
   localparam logic [7:0]  MAKER_CODE    = 8'h5e; // Arbitrary value, not a real code.
   localparam int          ADDR_BYTES    = 3;

   typedef struct packed {
      logic write_in_progress;
      logic write_latch_bit;
      logic paused_flag;
      logic [7:0] read_param_bits;
      logic [7:0] continuous_read_bits;
      logic [2:0] wrap_setting_bits;
   } volatile_t;

   localparam volatile_t VOL_RESET = '0;

   typedef struct packed {
      logic       sck;
      logic       sel_n;
      logic       sdi;
   } link_t;
endpackage

/* File: link_sync.sv */
// Two-stage synchroniser for the serial pins with serial clock edge detection.
`timescale 1ns/10ps
module link_sync
   import spi_cmd_pkg::*;
(
   input  wire logic  sys_clk,   // System clock.
   input  wire logic  rst,       // Asynchronous reset.
   input  wire link_t pins_in,   // Raw serial pins.
   output link_t      pins_sync, // Synchronised pins.
   output logic       sck_rise,  // Serial clock rising edge pulse.
   output logic       sck_fall   // Serial clock falling edge pulse.
);
   link_t s1_reg;
   link_t s2_reg;
   logic  sck_d_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_reg    <= '{sck: 1'b0, sel_n: 1'b1, sdi: 1'b0};
         s2_reg    <= '{sck: 1'b0, sel_n: 1'b1, sdi: 1'b0};
         sck_d_reg <= 1'b0;
      end else begin
         s1_reg    <= pins_in;
         s2_reg    <= s1_reg;
         sck_d_reg <= s2_reg.sck;
      end
   end

   assign pins_sync = s2_reg;
   assign sck_rise  = s2_reg.sck & ~sck_d_reg;
   assign sck_fall  = ~s2_reg.sck & sck_d_reg;
endmodule

/* File: disc_rom.sv */
// Read-only discovery header table.
`timescale 1ns/10ps
module disc_rom
   import spi_cmd_pkg::*;
(
   input  wire logic [7:0] addr, // Byte address.
   output logic [7:0]      data  // Table byte.
);
   always_comb begin
      case (addr)
         8'h00: data = 8'h53;
         8'h01: data = 8'h46;
         8'h02: data = 8'h44;
         8'h03: data = 8'h50;
         8'h04: data = 8'h00;
         8'h05: data = 8'h01;
         8'h06: data = 8'h01;
         8'h08: data = 8'h00;
         8'h09: data = 8'h00;
         8'h0a: data = 8'h01;
         8'h0b: data = 8'h09;
         8'h0c: data = 8'h30;
         8'h0d: data = 8'h00;
         8'h0e: data = 8'h00;
         8'h10: data = MAKER_CODE;
         8'h11: data = 8'h00;
         8'h12: data = 8'h01;
         8'h13: data = 8'h03;
         8'h14: data = 8'h60;
         8'h15: data = 8'h00;
         8'h16: data = 8'h00;
         default: data = BLANK_BYTE;
      endcase
   end
endmodule

/* File: sec_cmd.sv */
// Command interpreter for security pages, software reset and discovery table reads.
`timescale 1ns/10ps
module sec_cmd
   import spi_cmd_pkg::*;
#(
   parameter int PROG_CNT = PROG_CYCLES,
   parameter int RST_CNT  = RST_CYCLES
) (
   input  wire logic sys_clk,              // System clock, 250 MHz.
   input  wire logic rst,                  // Asynchronous reset, active high.
   input  wire logic select_n,             // Chip select pin, active low.
   input  wire logic serial_clock,         // Serial clock pin.
   input  wire logic serial_in,            // Serial data in pin.
   output logic      serial_out,           // Serial data out pin.
   output logic      serial_out_oe,        // Serial out drive enable.
   input  wire logic secure_lock_bit,      // Pages locked when high.
   output logic      write_in_progress,    // Busy status bit.
   output logic      write_latch_bit,      // Write enable latch.
   output logic      paused_flag,          // Suspend status bit.
   output logic [7:0] read_param_bits,     // Read parameter setting.
   output logic [7:0] continuous_read_bits,// Continuous read setting.
   output logic [2:0] wrap_setting_bits,   // Wrap setting.
   output logic      reset_busy            // High while commands are refused.
);
   typedef enum logic [5:0] {
      ST_OPC  = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_DUMY = 6'b000100,
      ST_DATA = 6'b001000,
      ST_PROG = 6'b010000,
      ST_SKIP = 6'b100000
   } state_t;

   link_t      pins_sync;
   logic       sck_rise;
   logic       sck_fall;
   state_t     state_reg;
   logic [7:0] sh_reg;
   logic [2:0] bit_reg;
   logic [1:0] abyte_reg;
   logic [7:0] opc_reg;
   logic [23:0] addr_reg;
   logic       prev_rsten_reg;
   logic       sel_d_reg;
   logic       prog_armed_reg;
   logic [31:0] prog_cnt_reg;
   logic [31:0] rst_cnt_reg;
   volatile_t  vol_reg;
   logic [7:0] mem [PAGE_COUNT*PAGE_BYTES];
   logic [7:0] pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pmask_reg;
   logic [1:0] ppage_reg;
   logic [7:0] out_reg;
   logic [7:0] rom_data;
   logic       oe_reg;
   logic       so_reg;
   logic [PAGE_COUNT*PAGE_BYTES-1:0] used_reg;
   link_t      pins_raw;

   assign pins_raw = '{sck: serial_clock, sel_n: select_n, sdi: serial_in};

   link_sync u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .pins_in  (pins_raw),
      .pins_sync(pins_sync),
      .sck_rise (sck_rise),
      .sck_fall (sck_fall)
   );

   disc_rom u_rom (
      .addr(addr_reg[7:0]),
      .data(rom_data)
   );

   wire       sel_rise  = pins_sync.sel_n & ~sel_d_reg;
   wire       active    = ~pins_sync.sel_n;
   wire [7:0] byte_in   = {sh_reg[6:0], pins_sync.sdi};
   wire       byte_done = sck_rise & (bit_reg == 3'd7);
   wire       refuse    = (rst_cnt_reg != 0);
   wire       rst_go    = sel_rise & (opc_reg == OP_RST) & prev_rsten_reg & ~refuse
                          & (state_reg == ST_SKIP);

   // Cells not programmed since the last block reset read as erased.
   function automatic logic [7:0] sec_byte(input logic [23:0] a);
      sec_byte = used_reg[a[9:0]] ? mem[a[9:0]] : BLANK_BYTE;
   endfunction

   wire [7:0] sec_data  = sec_byte(addr_reg);
   wire [7:0] disc_data = (addr_reg[23:8] == 16'h0000) ? rom_data : BLANK_BYTE;
   wire       commit    = prog_armed_reg & (prog_cnt_reg == 32'd1) & ~rst_go;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_d_reg <= 1'b1;
      end else begin
         sel_d_reg <= pins_sync.sel_n;
      end
   end

   // Frame parser: opcode, address, dummy byte and data phases.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OPC;
         sh_reg    <= 8'h00;
         bit_reg   <= 3'd0;
         abyte_reg <= 2'd0;
         opc_reg   <= 8'h00;
         addr_reg  <= ADDR_RESET;
      end else if (!active) begin
         state_reg <= ST_OPC;
         bit_reg   <= 3'd0;
         abyte_reg <= 2'd0;
      end else if (sck_rise) begin
         sh_reg  <= byte_in;
         bit_reg <= bit_reg + 3'd1;
         if (byte_done) begin
            case (state_reg)
               ST_OPC: begin
                  opc_reg <= byte_in;
                  if (refuse) begin
                     state_reg <= ST_SKIP;
                  end else if (byte_in == OP_PROG_SEC || byte_in == OP_READ_SEC
                               || byte_in == OP_DISC) begin
                     state_reg <= ST_ADDR;
                  end else begin
                     state_reg <= ST_SKIP;
                  end
               end
               ST_ADDR: begin
                  addr_reg  <= {addr_reg[15:0], byte_in};
                  abyte_reg <= abyte_reg + 2'd1;
                  if (abyte_reg == 2'(ADDR_BYTES - 1)) begin
                     state_reg <= (opc_reg == OP_PROG_SEC) ? ST_PROG : ST_DUMY;
                  end
               end
               ST_DUMY: state_reg <= ST_DATA;
               ST_DATA: begin
                  if (opc_reg == OP_DISC) begin
                     addr_reg <= addr_reg + 24'd1;
                  end else begin
                     addr_reg <= {addr_reg[23:8], addr_reg[7:0] + 8'd1};
                  end
               end
               ST_PROG: addr_reg <= {addr_reg[23:8], addr_reg[7:0] + 8'd1};
               default: state_reg <= ST_SKIP;
            endcase
         end
      end
   end

   // Output shifter, changes on falling serial clock edges.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_reg <= 8'h00;
         so_reg  <= 1'b0;
         oe_reg  <= 1'b0;
      end else if (!active) begin
         oe_reg <= 1'b0;
      end else if (sck_fall && state_reg == ST_DATA) begin
         oe_reg <= 1'b1;
         if (bit_reg == 3'd0) begin
            so_reg  <= (opc_reg == OP_DISC) ? disc_data[7] : sec_data[7];
            out_reg <= (opc_reg == OP_DISC) ? {disc_data[6:0], 1'b0}
                                            : {sec_data[6:0], 1'b0};
         end else begin
            so_reg  <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end

   assign serial_out    = so_reg;
   assign serial_out_oe = oe_reg;

   // Program buffer gathers data bytes; only written bytes are committed.
   // Frames sent while a cycle runs must not disturb the buffer being committed.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pmask_reg <= '0;
         ppage_reg <= 2'd0;
      end else if (sel_d_reg && !pins_sync.sel_n && !prog_armed_reg) begin
         pmask_reg <= '0;
      end else if (byte_done && state_reg == ST_PROG && !prog_armed_reg) begin
         pmask_reg[addr_reg[7:0]] <= 1'b1;
         ppage_reg <= addr_reg[9:8];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (byte_done && state_reg == ST_PROG && active && !prog_armed_reg) begin
         pbuf[addr_reg[7:0]] <= byte_in;
      end
   end

   // Flash cells program by clearing bits at the end of the timed cycle.
   always_ff @(posedge sys_clk) begin
      if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pmask_reg[i]) begin
               mem[{ppage_reg, 8'(i)}] <= sec_byte({14'h0000, ppage_reg, 8'(i)}) & pbuf[i];
            end
         end
      end
   end

   // Marks the cells that hold programmed data; an aborted cycle marks nothing.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         used_reg <= '0;
      end else if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pmask_reg[i]) begin
               used_reg[{ppage_reg, 8'(i)}] <= 1'b1;
            end
         end
      end
   end

   // Program cycle, status bits and software reset.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vol_reg        <= VOL_RESET;
         prog_armed_reg <= 1'b0;
         prog_cnt_reg   <= '0;
         rst_cnt_reg    <= '0;
         prev_rsten_reg <= 1'b0;
      end else if (rst_go) begin
         vol_reg        <= VOL_RESET;
         prog_armed_reg <= 1'b0;
         prog_cnt_reg   <= '0;
         rst_cnt_reg    <= 32'(RST_CNT);
         prev_rsten_reg <= 1'b0;
      end else begin
         if (refuse) begin
            rst_cnt_reg <= rst_cnt_reg - 32'd1;
         end
         if (sel_rise && !refuse && state_reg != ST_OPC) begin
            prev_rsten_reg <= (opc_reg == OP_RST_EN);
            if (opc_reg == OP_WRITE_ENABLE_COMMAND && state_reg == ST_SKIP && !vol_reg.write_in_progress) begin
               vol_reg.write_latch_bit <= 1'b1;
            end
         end
         if (sel_rise && state_reg == ST_PROG && pmask_reg != '0 && !refuse
             && !vol_reg.write_in_progress && vol_reg.write_latch_bit
             && !secure_lock_bit && addr_reg[23:10] == '0) begin
            prog_armed_reg            <= 1'b1;
            prog_cnt_reg              <= 32'(PROG_CNT);
            vol_reg.write_in_progress <= 1'b1;
            vol_reg.write_latch_bit   <= 1'b0;
         end else if (prog_armed_reg) begin
            prog_cnt_reg <= prog_cnt_reg - 32'd1;
            if (prog_cnt_reg == 32'd1) begin
               prog_armed_reg            <= 1'b0;
               vol_reg.write_in_progress <= 1'b0;
               vol_reg.write_latch_bit   <= 1'b0;
            end
         end
      end
   end

   assign write_in_progress    = vol_reg.write_in_progress;
   assign write_latch_bit      = vol_reg.write_latch_bit;
   assign paused_flag          = vol_reg.paused_flag;
   assign read_param_bits      = vol_reg.read_param_bits;
   assign continuous_read_bits = vol_reg.continuous_read_bits;
   assign wrap_setting_bits    = vol_reg.wrap_setting_bits;
   assign reset_busy           = refuse;

   AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(write_in_progress) |-> write_in_progress [*8])
      else $error("busy dropped early");
   AST_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
      secure_lock_bit && !write_in_progress |=> !$rose(write_in_progress))
      else $error("program started while locked");
   AST_NO_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
      !write_latch_bit && !write_in_progress |=> !write_in_progress)
      else $error("program without write latch");
   AST_END_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(write_in_progress) && !$past(rst_go) |-> !write_latch_bit)
      else $error("latch still set after cycle");
   AST_START: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(write_in_progress) |-> $past(sel_rise) && $past(state_reg) == ST_PROG)
      else $error("program start without frame end");
   AST_RST_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      rst_go |=> !write_in_progress && !write_latch_bit && reset_busy)
      else $error("reset did not clear state");
   AST_REFUSE: assert property (@(posedge sys_clk) disable iff (rst)
      reset_busy && byte_done && state_reg == ST_OPC && active |=> state_reg == ST_SKIP)
      else $error("command accepted during reset recovery");
   AST_RST_PAIR: assert property (@(posedge sys_clk) disable iff (rst)
      sel_rise && opc_reg == OP_RST && !prev_rsten_reg && !reset_busy |=> !reset_busy)
      else $error("reset accepted without enable");
   AST_WRAP: assert property (@(posedge sys_clk) disable iff (rst)
      byte_done && active && state_reg == ST_DATA && opc_reg == OP_READ_SEC
      && addr_reg[7:0] == 8'hff
      |=> addr_reg[7:0] == 8'h00 && $stable(addr_reg[23:8]))
      else $error("read address did not wrap in page");
   AST_LATCH_START: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(write_in_progress) |-> !write_latch_bit)
      else $error("latch still set while programming");
   AST_OE_PHASE: assert property (@(posedge sys_clk) disable iff (rst)
      serial_out_oe && active |-> state_reg == ST_DATA)
      else $error("output driven outside data phase");
   COV_PROG: cover property (@(posedge sys_clk) disable iff (rst) $fell(write_in_progress));
   COV_RST: cover property (@(posedge sys_clk) disable iff (rst) rst_go);
   COV_DISC: cover property (@(posedge sys_clk) disable iff (rst)
      state_reg == ST_DATA && opc_reg == OP_DISC);
   COV_WRAP: cover property (@(posedge sys_clk) disable iff (rst)
      byte_done && state_reg == ST_DATA && addr_reg[7:0] == 8'hff);
endmodule

/* File: host_model.sv */
// Behavioural serial host that frames commands towards the command block.
`timescale 1ns/10ps
module host_model (
   input  wire logic sys_clk,      // System clock used for pacing.
   output logic      select_n,     // Chip select, active low.
   output logic      serial_clock, // Serial clock, idles low.
   output logic      serial_in,    // Serial data towards the device.
   input  wire logic serial_out    // Serial data from the device.
);
   initial begin
      select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in = 1'b0;
   end

   // Half a serial clock period of 64 ns.
   task automatic half();
      repeat (8) @(negedge sys_clk);
   endtask

   task automatic open_frame();
      @(negedge sys_clk);
      select_n = 1'b0;
      half();
   endtask

   // Sends one byte MSB first and captures the device byte on rising edges.
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in = tx[i];
         half();
         serial_clock = 1'b1;
         rx[i] = serial_out;
         half();
         serial_clock = 1'b0;
      end
   endtask

   // Ends the frame; the data line is not held at its last value afterwards.
   task automatic close_frame();
      half();
      select_n = 1'b1;
      serial_in = ~serial_in;
      half();
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the security page, reset and discovery command block.
`timescale 1ns/10ps
module tb_top
   import spi_cmd_pkg::*;
;
   localparam int PROG_N = 600;
   localparam int RST_N  = 400;

   logic       sys_clk, rst, secure_lock_bit;
   logic       select_n, serial_clock, serial_in, serial_out, serial_out_oe;
   logic       write_in_progress, write_latch_bit, paused_flag, reset_busy;
   logic [7:0] read_param_bits, continuous_read_bits;
   logic [2:0] wrap_setting_bits;
   int         errors, tests_run, seed, n, busy_n;
   logic [7:0] tx_buf [32];
   logic [7:0] rx_buf [32];
   logic [7:0] pm [4][256];
   logic [1:0] pg, pg2;
   logic       lat;
   logic [7:0] disc_q [$] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
                              8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
                              MAKER_CODE, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff,
                              8'hff};

   sec_cmd #(.PROG_CNT(PROG_N), .RST_CNT(RST_N)) u_sec_cmd (
      .sys_clk(sys_clk), .rst(rst), .select_n(select_n), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .secure_lock_bit(secure_lock_bit), .write_in_progress(write_in_progress),
      .write_latch_bit(write_latch_bit), .paused_flag(paused_flag),
      .read_param_bits(read_param_bits), .continuous_read_bits(continuous_read_bits),
      .wrap_setting_bits(wrap_setting_bits), .reset_busy(reset_busy));

   host_model u_host_model (
      .sys_clk(sys_clk), .select_n(select_n), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Counts the cycles seen busy and keeps the latch level seen with them.
   always @(negedge sys_clk) begin
      if (write_in_progress === 1'b1) begin
         busy_n <= busy_n + 1;
         lat    <= write_latch_bit;
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Waits a bounded number of cycles for busy (0) or reset recovery (1) to reach lvl.
   task automatic wait_sig(input int which, input logic lvl, input int max, output int cnt);
      cnt = 0;
      while (((which == 0) ? write_in_progress : reset_busy) !== lvl) begin
         if (cnt == max) begin
            errors++;
            test_done();
         end
         @(negedge sys_clk);
         cnt++;
      end
   endtask

   // One whole frame: opcode, hdr address and dummy bytes, then n data bytes.
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int hdr,
                        input int n);
      logic [7:0] hb [5];
      logic [7:0] junk;
      hb = '{op, a[23:16], a[15:8], a[7:0], 8'h00};
      u_host_model.open_frame();
      for (int i = 0; i <= hdr; i++) u_host_model.xbyte(hb[i], junk);
      for (int i = 0; i < n; i++) u_host_model.xbyte(tx_buf[i], rx_buf[i]);
      u_host_model.close_frame();
   endtask

   task automatic vol_chk(input logic exp_latch);
      chk(32'({write_latch_bit, paused_flag, read_param_bits, continuous_read_bits,
               wrap_setting_bits}), 32'({exp_latch, 20'h0}));
   endtask

   task automatic load_tx(input int cnt);
      for (int i = 0; i < cnt; i++) tx_buf[i] = 8'($random(seed)) & 8'($random(seed));
   endtask

   task automatic no_busy();
      logic acc;
      acc = 1'b0;
      repeat (40) @(negedge sys_clk) acc = acc | write_in_progress;
      chk(32'(acc), 32'h0);
   endtask

   // Reads cnt bytes from offset off of page p and compares with the model.
   task automatic read_chk(input logic [1:0] p, input logic [7:0] off, input int cnt);
      frame(OP_READ_SEC, {8'h00, 6'h00, p, off}, 4, cnt);
      for (int i = 0; i < cnt; i++)
         chk(32'(rx_buf[i]), 32'(pm[p][8'(off + i)]));
      chk(32'(serial_out_oe), 32'h0);
   endtask

   initial begin
      #300000;
      errors++;
      test_done();
   end

   initial begin
      errors = 0;
      tests_run = 0;
      seed = 39;
      rst = 1'b1;
      secure_lock_bit = 1'b0;
      for (int p = 0; p < 4; p++) for (int b = 0; b < 256; b++) pm[p][b] = 8'hff;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      vol_chk(1'b0);
      chk(32'({write_in_progress, reset_busy, serial_out_oe}), 32'h0);
      frame(OP_DISC, 24'h000000, 4, 25);
      for (int i = 0; i < 25; i++)
         chk(32'(rx_buf[i]), 32'(disc_q[i]));
      frame(OP_DISC, 24'h00000f, 4, 3);
      for (int i = 0; i < 3; i++) chk(32'(rx_buf[i]), 32'(disc_q[15 + i]));
      pg = 2'($random(seed));
      pg2 = pg + 2'd1;
      load_tx(4);
      // Program without the latch, then with the lock set.
      frame(OP_PROG_SEC, {8'h00, 6'h00, pg, 8'hfe}, 3, 4);
      no_busy();
      secure_lock_bit = 1'b1;
      frame(OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0);
      chk(32'(write_latch_bit), 32'h1);
      frame(OP_PROG_SEC, {8'h00, 6'h00, pg, 8'hfe}, 3, 4);
      no_busy();
      secure_lock_bit = 1'b0;
      // Accepted program across the end of the page.
      frame(OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0);
      busy_n = 0;
      lat = 1'b1;
      frame(OP_PROG_SEC, {8'h00, 6'h00, pg, 8'hfe}, 3, 4);
      for (int i = 0; i < 4; i++) pm[pg][8'(8'hfe + i)] &= tx_buf[i];
      wait_sig(0, 1'b1, 40, n);
      wait_sig(0, 1'b0, PROG_N + 100, n);
      chk(32'(busy_n), 32'(PROG_N));
      chk(32'(lat), 32'h0);
      read_chk(pg, 8'hfe, 6);
      // A lone reset opcode must be ignored.
      frame(OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0);
      frame(OP_RST, 24'h0, 0, 0);
      repeat (8) @(negedge sys_clk);
      chk(32'({write_latch_bit, reset_busy}), 32'h2);
      // Reset sequence in mid-program, with a command sent during recovery.
      load_tx(2);
      frame(OP_PROG_SEC, {8'h00, 6'h00, pg2, 8'h10}, 3, 2);
      wait_sig(0, 1'b1, 40, n);
      frame(OP_RST_EN, 24'h0, 0, 0);
      frame(OP_RST, 24'h0, 0, 0);
      wait_sig(1, 1'b1, 40, n);
      repeat (2) @(negedge sys_clk);
      chk(32'(write_in_progress), 32'h0);
      vol_chk(1'b0);
      frame(OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0);
      wait_sig(1, 1'b0, RST_N + 50, n);
      vol_chk(1'b0);
      read_chk(pg, 8'hfe, 4);
      read_chk(pg2, 8'h10, 2);
      test_done();
   end
endmodule
